// ### hw/reset_and_timing_reference.sv
// reset collector, module reset matrix and timing reference divider
// assumes synchronous inputs on ref_clk_in and an APB master
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module reset_and_timing_reference #(
  parameter int WDOG_TIMEOUT = rst_timing_pkg::WDOG_TIMEOUT_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic pwrup_reset_in,
  input wire logic ext_reset_n_in,
  input wire logic pll_bypass_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rst_timing_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic timing_reference_clock_out,
  output logic pll_enable_out,
  output logic [rst_timing_pkg::PLL_COUNT_W-1:0] pll_multiplier_count_out,
  output logic [rst_timing_pkg::GEN_CFG_W-1:0] gen_cfg_out,
  output logic cpu_reset_out,
  output logic ethernet_front_end_reset_out,
  output logic dma_reset_out,
  output logic host_interface_module_reset_out,
  output logic general_module_reset_out,
  output logic memory_ctrl_reset_out,
  output logic serial_module_reset_out,
  output logic port_c_line4_reset_out
);
  import rst_timing_pkg::*;

  logic [PLL_COUNT_W-1:0] pll_multiplier_count_ff;
  logic host_port_io_reset_ff;
  logic sw_reset_ff;
  logic [GEN_CFG_W-1:0] gen_cfg_ff;
  logic wdog_en_ff;
  logic [31:0] wdog_cnt_ff;
  logic wdog_reset_ff;
  logic [4:0] pwrup_cnt_ff;
  logic pwrup_fire_ff;
  logic [DEGLITCH_STAGES-1:0] deglitch_ff;
  logic ext_low_ff;
  logic [9:0] hw_cnt_ff;
  logic hw_reset_ff;
  logic hw_from_ext_ff;
  logic [9:0] hw_high_cnt_ff;
  logic [4:0] src_ff;
  logic [7:0] div_cnt_ff;
  logic ref_clk_ff;
  logic [7:0] divisor;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic ext_fire;
  logic [4:0] src;

  assign wr_en = psel_in && penable_in && pwrite_in;
  // read captured in setup so data stands at the access edge
  assign rd_en = psel_in && !penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign addr_ok = (paddr_in == PLL_CTRL_OFS) || (paddr_in == HOST_CTRL_OFS) ||
                   (paddr_in == SW_SERVICE_OFS) || (paddr_in == GEN_CFG_OFS) ||
                   (paddr_in == RST_STATUS_OFS) || (paddr_in == WDOG_CTRL_OFS);
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // registers cleared by the internal hard reset stay in hard domain
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pll_multiplier_count_ff <= PLL_COUNT_RESET;
      gen_cfg_ff <= GEN_CFG_RESET;
    end else if (hw_reset_ff || wdog_reset_ff) begin
      pll_multiplier_count_ff <= PLL_COUNT_RESET;
      gen_cfg_ff <= GEN_CFG_RESET;
    end else if (wr_en && paddr_in == PLL_CTRL_OFS) begin
      pll_multiplier_count_ff <= pwdata_in[PLL_COUNT_W-1:0];
    end else if (wr_en && paddr_in == GEN_CFG_OFS) begin
      gen_cfg_ff <= pwdata_in[GEN_CFG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      host_port_io_reset_ff <= 1'b0;
      wdog_en_ff <= 1'b0;
    end else if (hw_reset_ff || wdog_reset_ff) begin
      host_port_io_reset_ff <= 1'b0;
      wdog_en_ff <= 1'b0;
    end else begin
      if (wr_en && paddr_in == HOST_CTRL_OFS) begin
        host_port_io_reset_ff <= pwdata_in[HOST_RESET_BIT];
      end
      if (wr_en && paddr_in == WDOG_CTRL_OFS) begin
        wdog_en_ff <= pwdata_in[0];
      end
    end
  end

  // service write: one-cycle software reset and watchdog restart
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw_reset_ff <= 1'b0;
    end else begin
      sw_reset_ff <= wr_en && paddr_in == SW_SERVICE_OFS && pwdata_in[SW_SERVICE_KEY_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wdog_cnt_ff <= 32'h00000000;
      wdog_reset_ff <= 1'b0;
    end else if (!wdog_en_ff || (wr_en && paddr_in == SW_SERVICE_OFS)) begin
      wdog_cnt_ff <= 32'h00000000;
      wdog_reset_ff <= 1'b0;
    end else if (wdog_cnt_ff == 32'(WDOG_TIMEOUT - 1)) begin
      wdog_cnt_ff <= 32'h00000000;
      wdog_reset_ff <= 1'b1;
    end else begin
      wdog_cnt_ff <= wdog_cnt_ff + 32'h00000001;
      wdog_reset_ff <= 1'b0;
    end
  end

  // powerup counter with asynchronous clear
  // chip reset parks it saturated: no powerup event, no unknowns
  always_ff @(posedge ref_clk_in or posedge pwrup_reset_in or negedge reset_n_in) begin
    if (pwrup_reset_in) begin
      pwrup_cnt_ff <= 5'h00;
      pwrup_fire_ff <= 1'b0;
    end else if (!reset_n_in) begin
      pwrup_cnt_ff <= PWRUP_CNT_MAX;
      pwrup_fire_ff <= 1'b0;
    end else if (pwrup_cnt_ff != PWRUP_CNT_MAX) begin
      pwrup_cnt_ff <= pwrup_cnt_ff + 5'h01;
      pwrup_fire_ff <= (pwrup_cnt_ff == PWRUP_CNT_MAX - 5'h01);
    end else begin
      pwrup_fire_ff <= 1'b0;
    end
  end

  // external pin deglitch, fire on release
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      deglitch_ff <= '1;
      ext_low_ff <= 1'b0;
    end else begin
      deglitch_ff <= {deglitch_ff[DEGLITCH_STAGES-2:0], ext_reset_n_in};
      if (deglitch_ff == '0) begin
        ext_low_ff <= 1'b1;
      end else if (deglitch_ff == '1) begin
        ext_low_ff <= 1'b0;
      end
    end
  end
  assign ext_fire = ext_low_ff && (deglitch_ff == '1);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hw_cnt_ff <= 10'h000;
      hw_reset_ff <= 1'b0;
      hw_from_ext_ff <= 1'b0;
    end else if (pwrup_fire_ff || ext_fire) begin
      hw_cnt_ff <= 10'h000;
      hw_reset_ff <= 1'b1;
      hw_from_ext_ff <= ext_fire;
    end else if (hw_reset_ff) begin
      hw_cnt_ff <= hw_cnt_ff + 10'h001;
      hw_reset_ff <= (hw_cnt_ff != HW_RESET_CNT_LAST);
    end
  end

  // pin held low resets nothing until release
  assign src = {sw_reset_ff, host_port_io_reset_ff, wdog_reset_ff,
                hw_reset_ff && hw_from_ext_ff, hw_reset_ff && !hw_from_ext_ff};

  // asserted at once by matrix, released on a clock edge
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_ff <= 5'h1F;
    end else begin
      src_ff <= src;
    end
  end
  assign cpu_reset_out = |((src | src_ff) & MAP_CPU);
  assign ethernet_front_end_reset_out = |((src | src_ff) & MAP_ALL);
  assign dma_reset_out = |((src | src_ff) & MAP_ALL);
  assign general_module_reset_out = |((src | src_ff) & MAP_ALL);
  assign serial_module_reset_out = |((src | src_ff) & MAP_ALL);
  assign host_interface_module_reset_out = |((src | src_ff) & MAP_HARD);
  assign memory_ctrl_reset_out = |((src | src_ff) & MAP_HARD);
  assign port_c_line4_reset_out = |((src | src_ff) & MAP_PORT_C_LINE4_RESET_OUT);

  // divider: PLL mode divides by count+3, giving crystal/12 at the reset count of 9
  always_comb begin
    if (pll_bypass_n_in) begin
      divisor = 8'(pll_multiplier_count_ff) + 8'(BYPASS_OFFSET);
    end else if (pll_multiplier_count_ff <= 4'(BYPASS_OFFSET)) begin
      divisor = 8'(BYPASS_MIN_DIV);
    end else begin
      divisor = 8'(pll_multiplier_count_ff) + 8'(BYPASS_OFFSET);
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt_ff <= 8'h00;
      ref_clk_ff <= 1'b0;
    end else if (div_cnt_ff >= divisor - 8'h01) begin
      div_cnt_ff <= 8'h00;
      ref_clk_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
      ref_clk_ff <= (div_cnt_ff + 8'h01) < (divisor >> 1);
    end
  end
  assign timing_reference_clock_out = ref_clk_ff;
  assign pll_enable_out = pll_bypass_n_in;
  assign pll_multiplier_count_out = pll_multiplier_count_ff;
  assign gen_cfg_out = gen_cfg_ff;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr_in)
        PLL_CTRL_OFS: prdata_out <= 32'(pll_multiplier_count_ff);
        HOST_CTRL_OFS: prdata_out <= 32'(host_port_io_reset_ff);
        GEN_CFG_OFS: prdata_out <= 32'(gen_cfg_ff);
        RST_STATUS_OFS: prdata_out <= {27'h0, src};
        WDOG_CTRL_OFS: prdata_out <= 32'(wdog_en_ff);
        default: prdata_out <= 32'h00000000;
      endcase
    end
  end

  // hardware reset window: rise, then held
  sequence hw_start_s;
    $rose(hw_reset_ff);
  endsequence
  sequence hw_hold_s;
    hw_reset_ff [*8];
  endsequence

  // length of the hardware reset window, checked on its fall
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hw_high_cnt_ff <= 10'h000;
    end else if (!hw_reset_ff) begin
      hw_high_cnt_ff <= 10'h000;
    end else if (hw_high_cnt_ff != 10'h3FF) begin
      hw_high_cnt_ff <= hw_high_cnt_ff + 10'h001;
    end
  end

  hw_len_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    hw_start_s |-> hw_hold_s) else $error("hw reset too short");
  hw_total_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $fell(hw_reset_ff) |-> hw_high_cnt_ff == 10'(HW_RESET_CYCLES))
    else $error("hw reset not 512 cycles");
  pwr_count_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !pwrup_reset_in && pwrup_cnt_ff != PWRUP_CNT_MAX |=> pwrup_reset_in
    || pwrup_cnt_ff == $past(pwrup_cnt_ff) + 5'h01) else $error("powerup count stalled");
  pwr_clear_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pwrup_reset_in |-> pwrup_cnt_ff == 5'h00) else $error("powerup count not cleared");
  ext_filter_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !ext_low_ff && deglitch_ff != '0 |=> !ext_low_ff) else $error("pin glitch accepted");
  ext_wait_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    deglitch_ff == '0 && !hw_reset_ff && !pwrup_fire_ff |=> !hw_reset_ff)
    else $error("reset while pin low");
  wdog_fire_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wdog_en_ff && wdog_cnt_ff == 32'(WDOG_TIMEOUT - 1)
    && !(wr_en && paddr_in == SW_SERVICE_OFS) |=> wdog_reset_ff)
    else $error("watchdog expiry missed");
  wdog_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_en && paddr_in == SW_SERVICE_OFS |=> !wdog_reset_ff)
    else $error("serviced watchdog fired");
  sw_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_en && paddr_in == SW_SERVICE_OFS && pwdata_in[SW_SERVICE_KEY_BIT] |=> sw_reset_ff
    && ethernet_front_end_reset_out && dma_reset_out && serial_module_reset_out
    && general_module_reset_out) else $error("software reset missing");
  mem_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    |($past(src) & MAP_HARD) |-> memory_ctrl_reset_out && host_interface_module_reset_out)
    else $error("module reset released early");
  cfg_keep_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !hw_reset_ff && !wdog_reset_ff && !(wr_en && paddr_in == GEN_CFG_OFS) |=>
    $stable(gen_cfg_ff)) else $error("config lost on soft reset");
  read_data_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    psel_in && penable_in && !pwrite_in && paddr_in == PLL_CTRL_OFS |->
    prdata_out == 32'(pll_multiplier_count_ff)) else $error("read data not ready");
  pwr_fire_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    pwrup_fire_ff |-> pwrup_cnt_ff == PWRUP_CNT_MAX) else $error("powerup fire early");
  ext_fire_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ext_fire |=> hw_reset_ff) else $error("external release no reset");
  host_rst_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    host_port_io_reset_ff |-> cpu_reset_out && !memory_ctrl_reset_out || hw_reset_ff
    || wdog_reset_ff) else $error("host reset matrix wrong");
  sw_cpu_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(sw_reset_ff) && src[3:0] == 4'h0 && src_ff[3:0] == 4'h0 |-> !cpu_reset_out
    && port_c_line4_reset_out) else $error("software reset hit cpu");
  pc4_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    port_c_line4_reset_out |-> sw_reset_ff || host_port_io_reset_ff || $past(sw_reset_ff)
    || $past(host_port_io_reset_ff) || !$past(reset_n_in)) else $error("pc4 wrong");
  cnt_rst_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(hw_reset_ff) |=> pll_multiplier_count_ff == PLL_COUNT_RESET)
    else $error("count not nine");
  div_mode_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !pll_bypass_n_in && pll_multiplier_count_ff <= 4'h3 |-> divisor == 8'h06)
    else $error("bypass divide wrong");
endmodule : reset_and_timing_reference

// ### hw/rst_timing_pkg.sv
// constants for the reset and timing reference block
// assumes a 50 MHz system clock and APB register access
package rst_timing_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] PLL_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_CTRL_OFS = 8'h04;
  localparam logic [7:0] SW_SERVICE_OFS = 8'h08;
  localparam logic [7:0] GEN_CFG_OFS = 8'h0C;
  localparam logic [7:0] RST_STATUS_OFS = 8'h10;
  localparam logic [7:0] WDOG_CTRL_OFS = 8'h14;
  localparam logic [3:0] PLL_COUNT_RESET = 4'h9;
  localparam int PLL_COUNT_W = 4;
  localparam int PRE_DIV = 5;
  localparam int BYPASS_MIN_DIV = 6;
  localparam int BYPASS_OFFSET = 3;
  localparam int PWRUP_CNT_W = 5;
  localparam logic [4:0] PWRUP_CNT_MAX = 5'h1F;
  localparam int DEGLITCH_STAGES = 6;
  localparam int HW_RESET_CYCLES = 512;
  localparam logic [9:0] HW_RESET_CNT_LAST = 10'h1FF;
  localparam int WDOG_TIMEOUT_DEFAULT = 65536;
  localparam int SW_SERVICE_KEY_BIT = 0;
  localparam int HOST_RESET_BIT = 0;
  localparam int GEN_CFG_W = 16;
  localparam logic [15:0] GEN_CFG_RESET = 16'h0000;
  // reset source index
  localparam int SRC_PWRUP = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_WDOG = 2;
  localparam int SRC_HOST = 3;
  localparam int SRC_SW = 4;
  // reset matrix per module: bit per source
  localparam logic [4:0] MAP_CPU = 5'h0F;
  localparam logic [4:0] MAP_ALL = 5'h1F;
  localparam logic [4:0] MAP_HARD = 5'h07;
  localparam logic [4:0] MAP_PORT_C_LINE4_RESET_OUT = 5'h18;
endpackage : rst_timing_pkg

// ### verif/reset_circuit_model.sv
// outside reset circuit and clock source strap
// assumes one clock; hold times are counted in its cycles
`timescale 1ns/1ps
module reset_circuit_model #(
  parameter int PWRUP_HOLD = 40,
  parameter int MIN_LOW = 50
) (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic bypass_req_in,
  output logic ext_reset_n_out,
  output logic pll_bypass_n_out
);
  // power-on hold shortened to keep runs short; MIN_LOW is 1us at 50 MHz
  int low_left = PWRUP_HOLD;
  assign pll_bypass_n_out = ~bypass_req_in;
  always @(posedge clk_in) begin
    if (start_in) begin
      low_left <= MIN_LOW;
    end else if (low_left > 0) begin
      low_left <= low_left - 1;
    end
  end
  assign ext_reset_n_out = (low_left == 0);
endmodule : reset_circuit_model

// ### verif/reset_and_timing_reference_tb.sv
// self-checking bench for the reset and timing reference block
// assumes the package and the reset circuit model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
      fail_count++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); \
    end \
  end
module reset_and_timing_reference_tb;
  import rst_timing_pkg::*;
  localparam int WDOG = 64;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, pwrup_reset_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [31:0] prdata_out, rd;
  logic pready_out, pslverr_out, timing_reference_clock_out, pll_enable_out, err;
  logic [PLL_COUNT_W-1:0] pll_multiplier_count_out;
  logic [GEN_CFG_W-1:0] gen_cfg_out, g;
  logic cpu_r, efe_r, dma_r, host_r, gen_r, mem_r, ser_r, pc4_r;
  logic ext_reset_n_in, pll_bypass_n_in, bypass_req = 1'b0, pin_start = 1'b0;
  logic [7:0] seen;
  int fail_count = 0, samples_checked = 0, cycles = 0, n, p;
  wire [7:0] rst_vec = {cpu_r, efe_r, dma_r, host_r, gen_r, mem_r, ser_r, pc4_r};
  reset_and_timing_reference #(.WDOG_TIMEOUT(WDOG)) i_reset_and_timing_reference (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .pwrup_reset_in(pwrup_reset_in),
    .ext_reset_n_in(ext_reset_n_in), .pll_bypass_n_in(pll_bypass_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .timing_reference_clock_out(timing_reference_clock_out),
    .pll_enable_out(pll_enable_out), .pll_multiplier_count_out(pll_multiplier_count_out),
    .gen_cfg_out(gen_cfg_out), .cpu_reset_out(cpu_r), .ethernet_front_end_reset_out(efe_r),
    .dma_reset_out(dma_r), .host_interface_module_reset_out(host_r),
    .general_module_reset_out(gen_r), .memory_ctrl_reset_out(mem_r),
    .serial_module_reset_out(ser_r), .port_c_line4_reset_out(pc4_r));
  reset_circuit_model i_reset_circuit_model (.clk_in(ref_clk_in), .start_in(pin_start),
    .bypass_req_in(bypass_req), .ext_reset_n_out(ext_reset_n_in),
    .pll_bypass_n_out(pll_bypass_n_in));
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  // expected matrix: cpu efe dma host gen mem ser port_c_line4_reset_out
  function automatic logic [7:0] exp_map(input int s);
    logic hard;
    hard = (s < SRC_HOST);
    return {(s != SRC_SW), 2'b11, hard, 1'b1, hard, 1'b1, ~hard};
  endfunction : exp_map
  task automatic collect(input int cnt);
    repeat (cnt) begin
      @(posedge ref_clk_in);
      seen |= rst_vec;
    end
  endtask : collect
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    collect(1);
    penable_in <= 1'b1;
    do begin
      collect(1);
      k++;
    end while (pready_out !== 1'b1 && k < 50);
    err = pslverr_out;
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    collect(1);
  endtask : apb
  task automatic wait_low();
    n = 0;
    while (cpu_r === 1'b1 && n < 2000) begin
      @(posedge ref_clk_in);
      n++;
    end
  endtask : wait_low
  task automatic hw_cycle(input int lo, input int hi, input int src);
    n = 0;
    while (cpu_r !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_in);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    `CHK(rst_vec, exp_map(src))
    wait_low();
    if (src != SRC_WDOG) `CHK(n, HW_RESET_CYCLES + 1)
    `CHK(pll_multiplier_count_out, 4'h9)
    `CHK(gen_cfg_out, 16'h0000)
  endtask : hw_cycle
  task automatic ext_cycle();
    n = 0;
    while (ext_reset_n_in !== 1'b1 && n < 200) begin
      @(posedge ref_clk_in);
      n++;
    end
    hw_cycle(DEGLITCH_STAGES - 1, DEGLITCH_STAGES + 3, SRC_EXT);
  endtask : ext_cycle
  task automatic set_cfg();
    g = 16'($urandom);
    apb(1'b1, GEN_CFG_OFS, {16'h0000, g});
    apb(1'b1, PLL_CTRL_OFS, 32'h2);
  endtask : set_cfg
  task automatic ref_period();
    logic last, cur;
    int k;
    cur = timing_reference_clock_out;
    p = 0;
    k = 0;
    while (k < 3 && p < 400) begin
      last = cur;
      @(posedge ref_clk_in);
      cur = timing_reference_clock_out;
      p++;
      if (cur === 1'b1 && last === 1'b0) begin
        k++;
        if (k < 3) p = 0;
      end
    end
  endtask : ref_period
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  initial begin
    void'($urandom(32'h8E119038));
    repeat (16) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    ext_cycle();
    apb(1'b0, PLL_CTRL_OFS, 32'h0);
    `CHK(rd[3:0], 4'h9)
    $display("test power_pin done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        bypass_req <= m[0];
        apb(1'b1, PLL_CTRL_OFS, 32'(c));
        ref_period();
        `CHK(p, (m == 1 && c <= 3) ? BYPASS_MIN_DIV : c + BYPASS_OFFSET)
        `CHK(pll_enable_out, ~m[0])
      end
    end
    bypass_req <= 1'b0;
    $display("test divider done");
    set_cfg();
    apb(1'b1, HOST_CTRL_OFS, 32'h1);
    seen = 8'h00;
    collect(40);
    `CHK(seen, exp_map(SRC_HOST))
    apb(1'b1, HOST_CTRL_OFS, 32'h0);
    collect(2);
    seen = 8'h00;
    collect(8);
    `CHK(seen, 8'h00)
    seen = 8'h00;
    apb(1'b1, SW_SERVICE_OFS, 32'h1);
    collect(3);
    `CHK(seen, exp_map(SRC_SW))
    `CHK(gen_cfg_out, g)
    apb(1'b0, 8'hFC, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test soft_host done");
    pin_start <= 1'b1;
    @(posedge ref_clk_in);
    pin_start <= 1'b0;
    seen = 8'h00;
    collect(40);
    `CHK(seen, 8'h00)
    ext_cycle();
    set_cfg();
    pwrup_reset_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    pwrup_reset_in <= 1'b0;
    hw_cycle(31 - 2, 31 + 4, SRC_PWRUP);
    $display("test hard done");
    set_cfg();
    apb(1'b1, WDOG_CTRL_OFS, 32'h1);
    seen = 8'h00;
    repeat (6) begin
      collect(8 + $urandom % (WDOG / 2));
      apb(1'b1, SW_SERVICE_OFS, 32'h0);
    end
    `CHK(seen, 8'h00)
    hw_cycle(WDOG - 8, WDOG + 8, SRC_WDOG);
    $display("test watchdog done");
    results();
  end
endmodule : reset_and_timing_reference_tb
